// File: test/test_sleep_wakeup_event_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_sleep_wakeup_event_logic;
  import wake_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq, pwr_en, core_rst, wake, asleep, lcd, main_sup, pin0, pin1, rx, xrst_n;
  logic [23:0] oe, pullups;
  analog_events_t ev;
  logic go = 1'b0;
  logic [3:0] kind = 4'h0;
  logic [7:0] got;
  int miscompares = 0;
  int checks_done = 0;
  // Columns: event kind, config address and value, flag address, mask, expected.
  logic [3:0] kd [10] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h3, 4'h1};
  logic [7:0] ca [10] = '{8'hC0, 8'hC0, 8'hEC, 8'hF3, 8'hA1, 8'hC0, 8'hC0, 8'hF4, 8'hEC, 8'hC0};
  logic [7:0] cd [10] = '{8'h10, 8'h10, 8'h01, 8'h01, 8'h02, 8'h11, 8'h1C, 8'h03, 8'h00, 8'h10};
  logic [7:0] fa [10] = '{8'hA1, 8'hC1, 8'hEC, 8'hEC, 8'hA1, 8'h88, 8'h88, 8'hF4, 8'hA1, 8'hF4};
  logic [7:0] fm [10] = '{8'h40, 8'h03, 8'h02, 8'h08, 8'h80, 8'h02, 8'h08, 8'h80, 8'h40, 8'h40};
  logic [7:0] fe [10] = '{8'h40, 8'h00, 8'h02, 8'h08, 8'h80, 8'h00, 8'h00, 8'h80, 8'h40, 8'h40};
  always #2.5 clk_i = ~clk_i;
  sleep_wakeup_event_logic #(.PINS(8)) sleep_wakeup_event_logic_i (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .ce_i(ce), .avs_address_i(addr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .events_i(ev), .on_main_supply_i(main_sup),
    .ext_irq_zero_pin_i(pin0), .ext_irq_one_pin_i(pin1), .rx_line_i(rx),
    .ext_reset_n_i(xrst_n), .core_power_en_o(pwr_en), .core_reset_o(core_rst),
    .wake_request_o(wake), .deep_sleep_state_o(asleep), .lcd_enable_o(lcd),
    .pin_oe_allowed_o(oe), .pullup_en_o(pullups));
  wake_partner wake_partner_i (.clk_i(clk_i), .go_i(go), .kind_i(kind), .events_o(ev),
    .main_o(main_sup), .zero_o(pin0), .one_o(pin1), .rx_o(rx), .rst_n_o(xrst_n));
  task test_done;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wr_s <= w;
    rd_s <= !w;
    wdata <= {24'h0, d};
    @(posedge clk_i);
    while (waitreq !== 1'b0) @(posedge clk_i);
    got = rdata[7:0];
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    // Let the write settle before anyone looks at its effect.
    @(negedge clk_i);
  endtask
  task fire(input logic [3:0] k);
    @(posedge clk_i);
    kind <= k;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (30) @(negedge clk_i) if (wake === 1'b1) break;
  endtask
  task run_case(input int i);
    bus(1'b1, TIMER_CONTROL_OFS, 8'h05);
    bus(1'b1, ca[i], cd[i]);
    bus(1'b1, POWER_CONTROL_OFS, 8'h10);
    @(negedge clk_i);
    chk({7'h0, asleep}, 8'h01);
    chk({7'h0, lcd}, 8'h01);
    fire(kd[i]);
    chk({7'h0, wake}, 8'(i != 8));
    if (i == 8) begin
      // A frozen block must not act on an event that arrives while the enable is low.
      @(posedge clk_i);
      ce <= 1'b0;
      fire(4'h0);
      chk({7'h0, wake}, 8'h00);
      @(posedge clk_i);
      ce <= 1'b1;
      fire(4'h0);
    end
    repeat (40) @(negedge clk_i) if (core_rst === 1'b0) break;
    chk({7'h0, core_rst}, 8'h00);
    bus(1'b0, fa[i], 8'h00);
    chk(got & fm[i], fe[i]);
    bus(1'b1, fa[i], 8'h00);
  endtask
  initial begin
    #100us;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(1'b0, PORT0_PULLUP_OFS, 8'h00);
    chk(got, PULLUP_RESET);
    bus(1'b1, PORT1_PULLUP_OFS, 8'h5A);
    chk(pullups[15:8], 8'h5A);
    bus(1'b0, 8'h10, 8'h00);
    chk(got, 8'h00);
    for (int s = 0; s < SCRATCH_COUNT; s++) bus(1'b1, SCRATCH1_OFS + s[7:0], 8'hA0 + s[7:0]);
    for (int i = 0; i < 10; i++) run_case(i);
    for (int s = 0; s < SCRATCH_COUNT; s++) begin
      bus(1'b0, SCRATCH1_OFS + s[7:0], 8'h00);
      chk(got, 8'hA0 + s[7:0]);
    end
    test_done;
  end
endmodule
bind sleep_wakeup_event_logic wake_chk #(.PINS(PINS)) wake_chk_i (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .ce_i(ce_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .events_i(events_i), .ext_reset_n_i(ext_reset_n_i),
  .core_power_en_o(core_power_en_o), .core_reset_o(core_reset_o),
  .wake_request_o(wake_request_o), .deep_sleep_state_o(deep_sleep_state_o),
  .pin_oe_allowed_o(pin_oe_allowed_o));
`default_nettype wire

// File: test/wake_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wake_chk
  import wake_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire analog_events_t events_i,
  input wire logic ext_reset_n_i,
  input wire logic core_power_en_o,
  input wire logic core_reset_o,
  input wire logic wake_request_o,
  input wire logic deep_sleep_state_o,
  input wire logic [3*PINS-1:0] pin_oe_allowed_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic asleep;
  assign asleep = deep_sleep_state_o && ce_i;
  power_gate_a: assert property (core_power_en_o == !deep_sleep_state_o)
    else $error("core power not tied to sleep");
  pins_input_a: assert property (
    deep_sleep_state_o |-> pin_oe_allowed_o == '0)
    else $error("pin drive allowed in sleep");
  restore_wake_a: assert property (
    asleep && events_i.supply_restored |-> ##[1:2] wake_request_o)
    else $error("supply restore did not wake");
  midnight_wake_a: assert property (
    asleep && events_i.midnight |-> ##[1:2] wake_request_o)
    else $error("midnight did not wake");
  pin_reset_a: assert property (
    asleep && $fell(ext_reset_n_i) |-> ##[1:2] wake_request_o)
    else $error("reset pin did not wake");
  wake_hold_a: assert property (
    $rose(wake_request_o) |->
      (wake_request_o && core_reset_o)[*8] ##[12:14] !wake_request_o)
    else $error("wake request length wrong");
  restart_held_a: assert property (
    wake_request_o |-> core_reset_o && !deep_sleep_state_o)
    else $error("core not held in restart");
  wake_source_a: assert property (
    $rose(wake_request_o) |-> $past(deep_sleep_state_o))
    else $error("wake outside sleep");
  run_again_a: assert property (
    $fell(wake_request_o) |-> !core_reset_o && core_power_en_o)
    else $error("core not released after wake");
  bus_ack_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("bus answer late");
  sleep_c: cover property ($rose(deep_sleep_state_o));
  wake_c: cover property ($rose(wake_request_o));
  read_c: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
`default_nettype wire

// File: test/wake_partner.sv
`timescale 1ns/1ps
`default_nettype none
module wake_partner
  import wake_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] kind_i,
  output analog_events_t events_o = '0,
  output logic main_o = 1'b0,
  output logic zero_o = 1'b1,
  output logic one_o = 1'b1,
  output logic rx_o = 1'b1,
  output logic rst_n_o = 1'b1
);
  // Events and the reset pin are one-cycle pulses; the IRQ and rx pins toggle so each request is one edge.
  always @(posedge clk_i) begin
    events_o.temp_change <= go_i && kind_i == 4'h4;
    events_o.ext_volt_change <= go_i && kind_i == 4'h3;
    events_o.supply_restored <= go_i && kind_i == 4'h1;
    events_o.midnight <= go_i && kind_i == 4'h0;
    events_o.alarm <= go_i && kind_i == 4'h5;
    rst_n_o <= !(go_i && kind_i == 4'h2);
    if (go_i) begin
      main_o <= (kind_i == 4'h1);
      zero_o <= zero_o ^ (kind_i == 4'h6);
      one_o <= one_o ^ (kind_i == 4'h7);
      rx_o <= rx_o ^ (kind_i >= 4'h8);
    end
  end
endmodule
`default_nettype wire

// File: verilog/edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic level_i,
  input wire logic fall_sel_i,
  input wire logic any_i,
  output logic hit_o
);
  logic prev_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_reg <= 1'b1;
    end else if (ce_i) begin
      prev_reg <= level_i;
    end
  end

  always_comb begin
    if (any_i) begin
      hit_o = prev_reg ^ level_i;
    end else if (fall_sel_i) begin
      hit_o = prev_reg & ~level_i;
    end else begin
      hit_o = ~prev_reg & level_i;
    end
  end
endmodule
`default_nettype wire

// File: verilog/sleep_wakeup_event_logic.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_event_logic
  import wake_pkg::*;
#(
  parameter int PINS = PORT_WIDTH
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire analog_events_t events_i,
  input wire logic on_main_supply_i,
  input wire logic ext_irq_zero_pin_i,
  input wire logic ext_irq_one_pin_i,
  input wire logic rx_line_i,
  input wire logic ext_reset_n_i,
  output logic core_power_en_o,
  output logic core_reset_o,
  output logic wake_request_o,
  output logic deep_sleep_state_o,
  output logic lcd_enable_o,
  output logic [3*PINS-1:0] pin_oe_allowed_o,
  output logic [3*PINS-1:0] pullup_en_o
);
  power_state_t state_reg;
  logic [7:0] tdelta_reg, pmie_reg, peripheral_config_reg_reg, timer_control_reg_reg, cal_reg, wcfg_reg;
  logic [7:0] scratch_reg [SCRATCH_COUNT];
  logic [7:0] pullup_reg [3];
  logic [$clog2(RESTART_CYCLES+1)-1:0] restart_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic zero_hit, one_hit, rx_hit, wr, rd, sleeping, reset_prev_reg, reset_fall;
  logic [1:0] rx_cfg, one_cfg;
  logic wake;

  // A write lands only at the edge where the master sees waitrequest low.
  assign wr = avs_write_i & ack_reg & ce_i;
  assign rd = avs_read_i & ~ack_reg & ce_i;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign sleeping = (state_reg == ST_SLEEP);
  assign rx_cfg = peripheral_config_reg_reg[PERIPHERAL_CONFIG_REG_RX_CFG_LSB +: 2];
  assign one_cfg = wcfg_reg[WCFG_ONE_LSB+1 +: 2];
  assign reset_fall = reset_prev_reg & ~ext_reset_n_i;

  edge_detect u_zero (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .level_i(ext_irq_zero_pin_i),
    .fall_sel_i(timer_control_reg_reg[TIMER_CONTROL_REG_ZERO_EDGE_BIT]), .any_i(1'b0), .hit_o(zero_hit));
  edge_detect u_one (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .level_i(ext_irq_one_pin_i),
    .fall_sel_i(timer_control_reg_reg[TIMER_CONTROL_REG_ONE_EDGE_BIT]), .any_i(1'b0), .hit_o(one_hit));
  edge_detect u_rx (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .level_i(rx_line_i),
    .fall_sel_i(1'b0), .any_i(1'b1), .hit_o(rx_hit));

  always_comb begin
    wake = 1'b0;
    if (sleeping) begin
      wake = (events_i.temp_change & tdelta_reg[TDELTA_TEMP_EN_BIT])
        | (events_i.ext_volt_change & pmie_reg[PMIE_EXT_VOLT_EN_BIT])
        | events_i.supply_restored
        | events_i.midnight
        | (events_i.alarm & cal_reg[CAL_ALARM_EN_BIT])
        | (zero_hit & wcfg_reg[WCFG_ZERO_LSB])
        | (one_hit & (one_cfg == ONE_WAKE_ON))
        | (rx_hit & (rx_cfg == RX_WAKE_ON))
        | reset_fall;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_prev_reg <= 1'b1;
    end else if (ce_i) begin
      reset_prev_reg <= ext_reset_n_i;
    end
  end

  // Sleep entry, wake and core restart sequencing.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_RUN;
      restart_cnt_reg <= '0;
      wake_request_o <= 1'b0;
    end else if (ce_i) begin
      case (state_reg)
        ST_RUN: begin
          if (wr && avs_address_i == POWER_CONTROL_OFS
              && avs_writedata_i[POWER_CONTROL_REG_SLEEP_BIT]) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            state_reg <= ST_RESTART;
            wake_request_o <= 1'b1;
            restart_cnt_reg <= '0;
          end
        end
        ST_RESTART: begin
          if (restart_cnt_reg == ($bits(restart_cnt_reg))'(RESTART_CYCLES - 1)) begin
            state_reg <= ST_RUN;
            wake_request_o <= 1'b0;
          end else begin
            restart_cnt_reg <= restart_cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  assign deep_sleep_state_o = sleeping;
  assign core_power_en_o = (state_reg != ST_SLEEP);
  assign core_reset_o = (state_reg != ST_RUN);
  assign lcd_enable_o = wcfg_reg[WCFG_LCD_EN_BIT];

  // Event flags: hardware set wins over a same-cycle software clear.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pmie_reg <= REG_RESET;
      peripheral_config_reg_reg <= REG_RESET;
      cal_reg <= REG_RESET;
      timer_control_reg_reg <= REG_RESET;
    end else if (ce_i) begin
      if (wr && avs_address_i == POWER_MGMT_IRQ_ENABLE_OFS) pmie_reg <= avs_writedata_i[7:0];
      if (wr && avs_address_i == PERIPHERAL_CONFIG_OFS) peripheral_config_reg_reg <= avs_writedata_i[7:0];
      if (wr && avs_address_i == CALENDAR_CONFIG_OFS) cal_reg <= avs_writedata_i[7:0];
      if (wr && avs_address_i == TIMER_CONTROL_OFS) timer_control_reg_reg <= avs_writedata_i[7:0];
      if (events_i.ext_volt_change) pmie_reg[PMIE_EXT_VOLT_FLAG_BIT] <= 1'b1;
      if (events_i.temp_change && tdelta_reg[TDELTA_TEMP_EN_BIT]) begin
        pmie_reg[PMIE_TEMP_FLAG_BIT] <= 1'b1;
      end
      if (events_i.supply_restored) pmie_reg[PMIE_SUPPLY_RESTORED_BIT] <= 1'b1;
      peripheral_config_reg_reg[PERIPHERAL_CONFIG_REG_SUPPLY_SRC_BIT] <= on_main_supply_i;
      if (rx_hit && rx_cfg == RX_WAKE_ON) peripheral_config_reg_reg[PERIPHERAL_CONFIG_REG_RX_FLAG_BIT] <= 1'b1;
      if (events_i.midnight) cal_reg[CAL_MIDNIGHT_FLAG_BIT] <= 1'b1;
      if (events_i.alarm && cal_reg[CAL_ALARM_EN_BIT]) begin
        cal_reg[CAL_ALARM_FLAG_BIT] <= 1'b1;
      end
      if (zero_hit && !sleeping) timer_control_reg_reg[TIMER_CONTROL_REG_ZERO_LATCH_BIT] <= 1'b1;
      if (one_hit && !sleeping) timer_control_reg_reg[TIMER_CONTROL_REG_ONE_LATCH_BIT] <= 1'b1;
    end
  end

  // Retained configuration: returned to reset values only by the always-on reset, never by sleep.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tdelta_reg <= REG_RESET;
      wcfg_reg <= REG_RESET;
      for (int i = 0; i < SCRATCH_COUNT; i++) scratch_reg[i] <= REG_RESET;
      for (int i = 0; i < 3; i++) pullup_reg[i] <= PULLUP_RESET;
    end else if (ce_i && wr) begin
      if (avs_address_i == TEMP_SUPPLY_DELTA_OFS) tdelta_reg <= avs_writedata_i[7:0];
      if (avs_address_i == WAKE_CFG_OFS) wcfg_reg <= avs_writedata_i[7:0];
      for (int i = 0; i < SCRATCH_COUNT; i++) begin
        if (avs_address_i == SCRATCH1_OFS + 8'(i)) begin
          scratch_reg[i] <= avs_writedata_i[7:0];
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (avs_address_i == PORT0_PULLUP_OFS + 8'(i)) begin
          pullup_reg[i] <= avs_writedata_i[7:0];
        end
      end
    end
  end

  genvar p;
  for (p = 0; p < 3; p++) begin : g_port
    assign pullup_en_o[p*PINS +: PINS] = PINS'(pullup_reg[p]);
    assign pin_oe_allowed_o[p*PINS +: PINS] = {PINS{~sleeping}};
  end

  // Bus answer: one wait cycle, then acknowledge.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (ce_i) begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
      if (rd) begin
        rdata_reg <= '0;
        case (avs_address_i)
          TEMP_SUPPLY_DELTA_OFS: rdata_reg[7:0] <= tdelta_reg;
          POWER_MGMT_IRQ_ENABLE_OFS: rdata_reg[7:0] <= pmie_reg;
          PERIPHERAL_CONFIG_OFS: rdata_reg[7:0] <= peripheral_config_reg_reg;
          TIMER_CONTROL_OFS: rdata_reg[7:0] <= timer_control_reg_reg;
          CALENDAR_CONFIG_OFS: rdata_reg[7:0] <= cal_reg;
          WAKE_CFG_OFS: rdata_reg[7:0] <= wcfg_reg;
          WAKE_STATUS_OFS: rdata_reg[1:0] <= state_reg;
          PORT0_PULLUP_OFS: rdata_reg[7:0] <= pullup_reg[0];
          PORT1_PULLUP_OFS: rdata_reg[7:0] <= pullup_reg[1];
          PORT2_PULLUP_OFS: rdata_reg[7:0] <= pullup_reg[2];
          SCRATCH1_OFS: rdata_reg[7:0] <= scratch_reg[0];
          SCRATCH1_OFS + 8'h01: rdata_reg[7:0] <= scratch_reg[1];
          SCRATCH1_OFS + 8'h02: rdata_reg[7:0] <= scratch_reg[2];
          SCRATCH1_OFS + 8'h03: rdata_reg[7:0] <= scratch_reg[3];
          default: rdata_reg <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/wake_pkg.sv
package wake_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] TEMP_SUPPLY_DELTA_OFS = 8'hF3;
  localparam logic [7:0] POWER_MGMT_IRQ_ENABLE_OFS = 8'hEC;
  localparam logic [7:0] PERIPHERAL_CONFIG_OFS = 8'hF4;
  localparam logic [7:0] TIMER_CONTROL_OFS = 8'h88;
  localparam logic [7:0] CALENDAR_CONFIG_OFS = 8'hA1;
  localparam logic [7:0] POWER_CONTROL_OFS = 8'hC5;
  localparam logic [7:0] PORT0_PULLUP_OFS = 8'hB2;
  localparam logic [7:0] PORT1_PULLUP_OFS = 8'hB3;
  localparam logic [7:0] PORT2_PULLUP_OFS = 8'hB4;
  localparam logic [7:0] SCRATCH1_OFS = 8'hFB;
  localparam logic [7:0] WAKE_CFG_OFS = 8'hC0;
  localparam logic [7:0] WAKE_STATUS_OFS = 8'hC1;
  localparam int PERIPHERAL_CONFIG_REG_RX_FLAG_BIT = 7;
  localparam int PERIPHERAL_CONFIG_REG_SUPPLY_SRC_BIT = 6;
  localparam int PERIPHERAL_CONFIG_REG_RX_CFG_LSB = 0;
  localparam int POWER_CONTROL_REG_SLEEP_BIT = 4;
  localparam int TDELTA_TEMP_EN_BIT = 0;
  localparam int PMIE_EXT_VOLT_EN_BIT = 0;
  localparam int PMIE_EXT_VOLT_FLAG_BIT = 1;
  localparam int PMIE_SUPPLY_RESTORED_BIT = 2;
  localparam int PMIE_TEMP_FLAG_BIT = 3;
  localparam int TIMER_CONTROL_REG_ZERO_EDGE_BIT = 0;
  localparam int TIMER_CONTROL_REG_ZERO_LATCH_BIT = 1;
  localparam int TIMER_CONTROL_REG_ONE_EDGE_BIT = 2;
  localparam int TIMER_CONTROL_REG_ONE_LATCH_BIT = 3;
  localparam int CAL_ALARM_EN_BIT = 1;
  localparam int CAL_MIDNIGHT_FLAG_BIT = 6;
  localparam int CAL_ALARM_FLAG_BIT = 7;
  localparam int WCFG_ZERO_LSB = 0;
  localparam int WCFG_ONE_LSB = 1;
  localparam int WCFG_LCD_EN_BIT = 4;
  localparam logic [1:0] RX_WAKE_ON = 2'h3;
  localparam logic [1:0] ONE_WAKE_ON = 2'h3;
  localparam logic [7:0] PULLUP_RESET = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SCRATCH_COUNT = 4;
  localparam int PORT_WIDTH = 8;
  localparam int RESTART_NS = 100;
  localparam int CLK_NS = 5;
  localparam int RESTART_CYCLES = (RESTART_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_RESTART} power_state_t;
  typedef struct packed {
    logic temp_change;
    logic ext_volt_change;
    logic supply_restored;
    logic midnight;
    logic alarm;
  } analog_events_t;
endpackage
